// ---- rtl/crt_addr_ctrl.v ----
// crt timing and video memory address controller with apb register access
`timescale 1ns/1ps
`default_nettype none
`include "crt_ctrl_map.vh"

// Contract
// - 14-bit video address: upper eight output-only, lower six bidirectional.
// - double row buffer: drive address only during dma, float otherwise.
// - single row buffer: drive address during first scan of each row.
// - repetitive addressing: drive always except horizontal and vertical retrace.
// - row-table with single or repetitive: also drive at row-boundary retrace.
// - during register access low six lines are inputs selecting the register.
// - data bus carries register data only while strobe active, else floats outside attribute assemble mode.
// - dma takes data from memory for row table fetch or attribute latch; code runs dma only for the row table fetch.
// - attribute assemble mode drives data bus writing attribute to row buffer.
// - host strobes low; read drivers enabled only while strobe asserted.
// - register write data captured on rising trailing edge of strobe.
// - format 8-240 chars, 2-256 rows, 1-32 scans per row.
// - hsync 1-128 chars, vsync 2-256 lines, 4-2048 total scan lines.
// - binary addresses span 16K locations over 14 lines.
// - sequential mode starts frame at table start register, enabling scroll.
// - auxiliary and break registers hold a status row while screen rolls.
// - row-table mode fetches each row start from contiguous or linked table; code ignores the linked bit and reads the pointer at the row base.
// - no buffer: addresses output on every displayable scan line.
// - all timing derived from the character clock.
// - interrupt high, cleared when status register is read.
module crt_addr_ctrl #(
    parameter AW = 14
) (
    input  wire          pclk,
    input  wire          presetn,
    input  wire          psel,
    input  wire          penable,
    input  wire          pwrite,
    input  wire [11:0]   paddr,
    input  wire [31:0]   pwdata,
    output reg  [31:0]   prdata,
    output wire          pready,
    output wire          pslverr,
    input  wire          chip_strobe_n,
    input  wire [AW-1:0] video_mem_addr_in,
    output reg  [AW-1:0] video_mem_addr_out,
    output wire [AW-1:0] video_mem_addr_oe,
    input  wire [7:0]    video_data_bus_in,
    output reg  [7:0]    video_data_bus_out,
    output wire          video_data_bus_oe,
    output reg           horiz_sync,
    output reg           vert_sync,
    output reg           row_boundary_n,
    output reg           dma_active,
    output reg           interrupt
);

// =====================================================================
// registers
// =====================================================================
reg  [7:0]  htotal;
reg  [6:0]  hsync_w;
reg  [7:0]  chars;
reg  [4:0]  scans;
reg  [7:0]  rows;
reg  [7:0]  vsync_w;
reg  [10:0] scan_total;
reg  [13:0] table_start;
reg  [13:0] aux1;
reg  [13:0] aux2;
reg  [7:0]  break1;
reg  [7:0]  break2;
reg  [4:0]  mode;
reg         running;
reg  [7:0]  host_regs [0:63];
reg  [7:0]  host_wdata;
reg  [5:0]  host_sel;
reg         strobe_d;

// timing state
reg  [7:0]  hcnt;
reg  [10:0] line_cnt;
reg  [4:0]  scan_cnt;
reg  [7:0]  row_cnt;
reg  [13:0] row_base;
reg  [13:0] char_addr;
reg  [13:0] next_row_base;
reg  [1:0]  fetch_phase;
reg  [7:0]  fetch_lo;
reg  [7:0]  attr_latch;

wire        apb_wr = psel & penable & pwrite;
wire        apb_rd = psel & penable & ~pwrite;
wire        soft_reset = apb_wr && (paddr == `REG_COMMAND) && (pwdata[7:0] == `CMD_RESET);
wire        strobe_on = ~chip_strobe_n;
wire [1:0]  buf_cfg = mode[`MODE_BUF_LSB +: 2];
wire        rowtable = mode[`MODE_ROWTABLE];

// zero-wait slave, no error cases beyond unmapped reads as zero
assign pready  = 1'b1;
assign pslverr = 1'b0;

// =====================================================================
// apb write side and command decode
// =====================================================================
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        htotal      <= `RST_HTOTAL;
        hsync_w     <= `RST_HSYNC_W;
        chars       <= `RST_CHARS;
        scans       <= `RST_SCANS;
        rows        <= `RST_ROWS;
        vsync_w     <= `RST_VSYNC_W;
        scan_total  <= `RST_SCAN_TOTAL;
        table_start <= 14'h0000;
        aux1        <= 14'h0000;
        aux2        <= 14'h0000;
        break1      <= 8'hff;
        break2      <= 8'hff;
        mode        <= 5'h00;
        running     <= 1'b0;
    end else if (soft_reset) begin
        running <= 1'b0;
        mode    <= 5'h00;
    end else if (apb_wr) begin
        case (paddr)
            `REG_HTOTAL:      htotal <= (pwdata[7:0] < 8'h07) ? 8'h07 : pwdata[7:0];
            `REG_HSYNC:       hsync_w <= pwdata[6:0];
            `REG_ROWFMT: begin
                chars <= (pwdata[7:0] < 8'h07) ? 8'h07 :
                         (pwdata[7:0] > 8'hef) ? 8'hef : pwdata[7:0];
                scans <= pwdata[12:8];
            end
            `REG_VFMT: begin
                rows       <= (pwdata[7:0] == 8'h00) ? 8'h01 : pwdata[7:0];
                vsync_w    <= (pwdata[15:8] == 8'h00) ? 8'h01 : pwdata[15:8];
                scan_total <= (pwdata[26:16] < 11'h003) ? 11'h003 : pwdata[26:16];
            end
            `REG_TABLE_START: table_start <= pwdata[13:0];
            `REG_AUX1:        aux1 <= pwdata[13:0];
            `REG_AUX2:        aux2 <= pwdata[13:0];
            `REG_BREAK1:      break1 <= pwdata[7:0];
            `REG_BREAK2:      break2 <= pwdata[7:0];
            `REG_MODE:        mode <= pwdata[4:0];
            `REG_COMMAND: begin
                if (pwdata[7:0] == `CMD_START) begin
                    running <= 1'b1;
                end
            end
            default: ;
        endcase
    end
end

// =====================================================================
// host strobe port: latch on trailing edge
// =====================================================================
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        strobe_d   <= 1'b0;
        host_wdata <= 8'h00;
        host_sel   <= 6'h00;
    end else begin
        strobe_d <= strobe_on;
        if (strobe_on) begin
            host_wdata <= video_data_bus_in;
            host_sel   <= video_mem_addr_in[5:0];
        end
    end
end

// written on strobe release with values held during the low phase
always @(posedge pclk) begin
    if (strobe_d && !strobe_on) begin
        host_regs[host_sel] <= host_wdata;
    end
end

// =====================================================================
// raster timing, one count per character clock
// =====================================================================
wire line_end  = (hcnt == htotal);
wire row_end   = (scan_cnt == scans);
wire frame_end = (line_cnt == scan_total);
wire hretrace  = (hcnt > chars);
// rows past the programmed count are vertical retrace; 14 bits hold 256 rows of 32 scans
wire vdisplay  = (row_cnt <= rows) &&
                 ({3'h0, line_cnt} < ({6'h00, rows} + 14'h0001) * ({9'h000, scans} + 14'h0001));
wire first_scan = (scan_cnt == 5'h00);

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        hcnt           <= 8'h00;
        line_cnt       <= 11'h000;
        scan_cnt       <= 5'h00;
        row_cnt        <= 8'h00;
        horiz_sync     <= 1'b1;
        vert_sync      <= 1'b1;
        row_boundary_n <= 1'b1;
    end else if (!running || soft_reset) begin
        hcnt       <= 8'h00;
        line_cnt   <= 11'h000;
        scan_cnt   <= 5'h00;
        row_cnt    <= 8'h00;
        horiz_sync <= 1'b1;
        vert_sync  <= 1'b1;
        row_boundary_n <= 1'b1;
    end else begin
        hcnt <= line_end ? 8'h00 : hcnt + 8'h01;
        horiz_sync <= ~((hcnt > chars) && (hcnt <= chars + {1'b0, hsync_w} + 8'h01));
        if (line_end) begin
            line_cnt <= frame_end ? 11'h000 : line_cnt + 11'h001;
            // sync is decided for the coming line, so it closes with the frame
            vert_sync <= ~(!frame_end && (line_cnt + 11'h001 >= scan_total - {3'h0, vsync_w}));
            if (frame_end) begin
                scan_cnt <= 5'h00;
                row_cnt  <= 8'h00;
            end else if (row_end) begin
                scan_cnt <= 5'h00;
                row_cnt  <= row_cnt + 8'h01;
            end else begin
                scan_cnt <= scan_cnt + 5'h01;
            end
            // marker only for displayed rows; retrace rows get none
            row_boundary_n <= ~(frame_end || (row_end && (row_cnt < rows)));
        end else if (hcnt == 8'h00 && line_cnt == 11'h000) begin
            // first line after start is the top of row zero too
            row_boundary_n <= 1'b0;
        end
    end
end

// =====================================================================
// addressing: sequential with status rows, or row table fetch
// =====================================================================
wire dma_fetch_slot = rowtable && hretrace && first_scan && (hcnt > chars + 8'h01)
                      && (fetch_phase != 2'h3);

always @* begin
    next_row_base = row_base + {6'h00, chars} + 14'h0001;
    if (row_cnt == break1) begin
        next_row_base = aux1;
    end else if (row_cnt == break2) begin
        next_row_base = aux2;
    end
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        row_base    <= 14'h0000;
        char_addr   <= 14'h0000;
        fetch_phase <= 2'h0;
        fetch_lo    <= 8'h00;
        attr_latch  <= 8'h00;
        dma_active  <= 1'b0;
    end else if (!running || soft_reset) begin
        row_base    <= table_start;
        char_addr   <= table_start;
        fetch_phase <= 2'h0;
        dma_active  <= 1'b0;
    end else begin
        dma_active <= dma_fetch_slot && !strobe_on;
        if (dma_fetch_slot && !strobe_on) begin
            fetch_phase <= fetch_phase + 2'h1;
        end
        // memory answers while the launched address stands, one cycle after
        // the slot, so the byte belongs to the phase before the count
        if (dma_active && !strobe_on) begin
            if (fetch_phase == 2'h1) begin
                fetch_lo <= video_data_bus_in;
            end else if (fetch_phase == 2'h2) begin
                row_base <= {video_data_bus_in[5:0], fetch_lo};
            end
        end
        if (mode[`MODE_ATTR] && hcnt == 8'h00 && first_scan) begin
            attr_latch <= video_data_bus_in;
        end
        if (line_end) begin
            fetch_phase <= 2'h0;
            if (frame_end) begin
                row_base  <= table_start;
                char_addr <= table_start;
            end else if (row_end && !rowtable) begin
                row_base  <= next_row_base;
                char_addr <= next_row_base;
            end else begin
                char_addr <= row_base;
            end
        end else if (!hretrace) begin
            char_addr <= char_addr + 14'h0001;
        end
    end
end

// =====================================================================
// bus drive decisions
// =====================================================================
reg addr_drive;
always @* begin
    case (buf_cfg)
        `BUF_DOUBLE: addr_drive = dma_active;
        `BUF_SINGLE: addr_drive = first_scan && vdisplay;
        default:     addr_drive = !hretrace && vdisplay;
    endcase
    if (rowtable && buf_cfg != `BUF_DOUBLE && dma_active) begin
        addr_drive = 1'b1;
    end
    // the strobe owns the low lines, so every drive source yields to it
    if (!running || strobe_on) begin
        addr_drive = 1'b0;
    end
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        video_mem_addr_out <= {AW{1'b0}};
    end else if (dma_fetch_slot) begin
        video_mem_addr_out <= row_base + {12'h000, fetch_phase};
    end else begin
        video_mem_addr_out <= char_addr;
    end
end

// upper lines output-only, lower six share the register select
assign video_mem_addr_oe = {AW{addr_drive}};

wire attr_write = mode[`MODE_ATTR] && running && hcnt == 8'h01 && first_scan && !strobe_on;
assign video_data_bus_oe = (strobe_on && !strobe_d) ? 1'b0 :
                           strobe_on ? 1'b1 : attr_write;

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        video_data_bus_out <= 8'h00;
    end else if (strobe_on) begin
        video_data_bus_out <= host_regs[video_mem_addr_in[5:0]];
    end else begin
        video_data_bus_out <= attr_latch;
    end
end

// =====================================================================
// interrupt and apb read
// =====================================================================
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        interrupt <= 1'b0;
    end else if (running && line_end && frame_end) begin
        interrupt <= 1'b1; // set wins over the read clear
    end else if (apb_rd && paddr == `REG_STATUS) begin
        interrupt <= 1'b0;
    end
end

always @* begin
    case (paddr)
        `REG_HTOTAL:      prdata = {24'h0, htotal};
        `REG_HSYNC:       prdata = {25'h0, hsync_w};
        `REG_ROWFMT:      prdata = {19'h0, scans, chars};
        `REG_VFMT:        prdata = {5'h0, scan_total, vsync_w, rows};
        `REG_TABLE_START: prdata = {18'h0, table_start};
        `REG_AUX1:        prdata = {18'h0, aux1};
        `REG_AUX2:        prdata = {18'h0, aux2};
        `REG_BREAK1:      prdata = {24'h0, break1};
        `REG_BREAK2:      prdata = {24'h0, break2};
        `REG_MODE:        prdata = {27'h0, mode};
        `REG_STATUS:      prdata = {22'h0, running, interrupt, row_cnt};
        `REG_HOSTREG:     prdata = {18'h0, host_sel, host_wdata};
        default:          prdata = 32'h0;
    endcase
end

endmodule
`default_nettype wire

// ---- common/crt_ctrl_map.vh ----
// register offsets, field layouts, reset values and commands of the crt address controller
`ifndef CRT_CTRL_MAP_VH
`define CRT_CTRL_MAP_VH

// apb byte offsets
`define REG_HTOTAL      12'h000
`define REG_HSYNC       12'h004
`define REG_ROWFMT      12'h008
`define REG_VFMT        12'h00c
`define REG_TABLE_START 12'h010
`define REG_AUX1        12'h014
`define REG_AUX2        12'h018
`define REG_BREAK1      12'h01c
`define REG_BREAK2      12'h020
`define REG_MODE        12'h024
`define REG_COMMAND     12'h028
`define REG_STATUS      12'h02c
`define REG_HOSTREG     12'h030

// mode register fields
`define MODE_BUF_LSB    0
`define MODE_ROWTABLE   2
`define MODE_ATTR       3
`define MODE_LINKED     4

// buffer configurations
`define BUF_NONE        2'h0
`define BUF_SINGLE      2'h1
`define BUF_DOUBLE      2'h2

// commands
`define CMD_RESET       8'h01
`define CMD_START       8'h02

// reset values
`define RST_HTOTAL      8'h63
`define RST_HSYNC_W     7'h07
`define RST_CHARS       8'h4f
`define RST_SCANS       5'h08
`define RST_ROWS        8'h17
`define RST_VSYNC_W     8'h02
`define RST_SCAN_TOTAL  11'h105

`endif

// ---- verification/crt_addr_ctrl_chk.sv ----
// concurrent checks on the pins of the crt address controller
`timescale 1ns/1ps
`default_nettype none
`include "crt_ctrl_map.vh"
module crt_addr_ctrl_chk #(
    parameter AW = 14
) (
    input wire logic          pclk,
    input wire logic          presetn,
    input wire logic          psel,
    input wire logic          penable,
    input wire logic          pwrite,
    input wire logic [11:0]   paddr,
    input wire logic [31:0]   pwdata,
    input wire logic          chip_strobe_n,
    input wire logic [AW-1:0] video_mem_addr_oe,
    input wire logic          video_data_bus_oe,
    input wire logic          horiz_sync,
    input wire logic          vert_sync,
    input wire logic          row_boundary_n,
    input wire logic          dma_active
);
    // ====
    // mirror of run and mode state
    logic       running;
    logic [4:0] mode;
    wire        wr = psel && penable && pwrite;
    wire        cmd = wr && paddr == `REG_COMMAND;
    wire        drv = |video_mem_addr_oe;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            running <= 1'b0;
            mode <= 5'h00;
        end else if (cmd && pwdata[7:0] == `CMD_START) begin
            running <= 1'b1;
        end else if (cmd && pwdata[7:0] == `CMD_RESET) begin
            running <= 1'b0;
            mode <= 5'h00;
        end else if (wr && paddr == `REG_MODE) begin
            mode <= pwdata[4:0];
        end
    end
    // ====
    // checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_strobe_addr_free: assert property (
        !chip_strobe_n |-> !drv) else $error("address driven under strobe");
    a_addr_oe_whole: assert property (
        video_mem_addr_oe == '0 || video_mem_addr_oe == '1) else $error("split address enable");
    a_idle_quiet: assert property (
        !running |-> horiz_sync && vert_sync && !drv) else $error("active while stopped");
    a_double_dma_only: assert property (
        mode[1:0] == `BUF_DOUBLE && !dma_active && !$past(dma_active) |-> !drv)
        else $error("double buffer address outside dma");
    a_single_first_scan: assert property (
        mode[1:0] == `BUF_SINGLE && !mode[2] && drv && $past(drv)
        |-> !row_boundary_n || $past(!row_boundary_n)) else $error("single buffer drive off row top");
    a_retrace_float: assert property (
        mode[1:0] == `BUF_NONE && !mode[2] && ((!horiz_sync && $past(!horiz_sync))
        || (!vert_sync && $past(!vert_sync))) |-> !drv) else $error("address driven in retrace");
    a_dma_addr_drive: assert property (
        dma_active && chip_strobe_n |-> drv) else $error("dma without address");
    a_data_float: assert property (
        chip_strobe_n && $past(chip_strobe_n) && !mode[3] |-> !video_data_bus_oe)
        else $error("data bus driven without strobe");
    a_read_drive: assert property (
        $fell(chip_strobe_n) |-> ##[1:2] video_data_bus_oe) else $error("no read drive");
endmodule
bind crt_addr_ctrl crt_addr_ctrl_chk #(.AW(AW)) u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .chip_strobe_n(chip_strobe_n), .video_mem_addr_oe(video_mem_addr_oe),
    .video_data_bus_oe(video_data_bus_oe), .horiz_sync(horiz_sync), .vert_sync(vert_sync),
    .row_boundary_n(row_boundary_n), .dma_active(dma_active));
`default_nettype wire

// ---- verification/vmem_model.sv ----
// video memory and pin resolution facing the controller
`timescale 1ns/1ps
`default_nettype none
module vmem_model (
    input  wire logic        pclk,
    input  wire logic [13:0] addr_out,
    input  wire logic [13:0] addr_oe,
    input  wire logic [7:0]  data_out,
    input  wire logic        data_oe,
    input  wire logic        host_en,
    input  wire logic        host_wr,
    input  wire logic [5:0]  host_sel,
    input  wire logic [7:0]  host_data,
    output logic      [13:0] addr_in,
    output logic      [7:0]  data_in
);
    // ====
    // a floating line shows the inverse of its last level, never a stale copy
    logic [13:0] last_a = 14'h0000;
    logic [7:0]  last_d = 8'h00;
    always_comb begin
        if (addr_oe[0])
            addr_in = addr_out;
        else if (host_en)
            addr_in = {~last_a[13:6], host_sel};
        else
            addr_in = ~last_a;
        if (host_en && host_wr)
            data_in = host_data;
        else if (data_oe)
            data_in = data_out;
        else if (addr_oe[0])
            data_in = addr_out[7:0] ^ 8'h5a;
        else
            data_in = ~last_d;
    end
    always @(posedge pclk) begin
        last_a <= addr_in;
        last_d <= data_in;
    end
endmodule
`default_nettype wire

// ---- verification/crt_addr_ctrl_test.sv ----
// self-checking bench for the crt address controller
`timescale 1ns/1ps
`default_nettype none
`include "crt_ctrl_map.vh"
module crt_addr_ctrl_test;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic        chip_strobe_n = 1'b1;
    logic        host_en = 1'b0;
    logic        host_wr = 1'b0;
    logic [5:0]  host_sel = 6'h00;
    logic [7:0]  host_data = 8'h00;
    logic [31:0] rd;
    wire  [31:0] prdata;
    wire  [13:0] a_in, a_out, a_oe;
    wire  [7:0]  d_in, d_out;
    wire         pready, pslverr, d_oe, hs, vs, rb_n, dma, irq;
    int          failures = 0;
    int          tests_run = 0;
    int          n_oe, n_dma, n_hs, n_vs, n_rb, n_do;
    crt_addr_ctrl #(.AW(14)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .chip_strobe_n(chip_strobe_n),
        .video_mem_addr_in(a_in), .video_mem_addr_out(a_out), .video_mem_addr_oe(a_oe),
        .video_data_bus_in(d_in), .video_data_bus_out(d_out), .video_data_bus_oe(d_oe),
        .horiz_sync(hs), .vert_sync(vs), .row_boundary_n(rb_n), .dma_active(dma),
        .interrupt(irq));
    vmem_model mem (.pclk(pclk), .addr_out(a_out), .addr_oe(a_oe), .data_out(d_out),
        .data_oe(d_oe), .host_en(host_en), .host_wr(host_wr), .host_sel(host_sel),
        .host_data(host_data), .addr_in(a_in), .data_in(d_in));
    initial begin
        forever #20 pclk = ~pclk;
    end
    // ====
    // shared tasks
    task summarize;
        begin
            $display("compared %0d, mismatched %0d", tests_run, failures);
            if (failures == 0 && tests_run > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        begin
            tests_run++;
            if (got !== exp) begin
                failures++;
                $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        begin
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            n = 0;
            @(posedge pclk);
            while (pready !== 1'b1) begin
                n++;
                if (n > 50) begin
                    failures++;
                    summarize;
                end
                @(posedge pclk);
            end
            rd = prdata;
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge pclk);
        end
    endtask
    task strobe(input logic w, input logic [5:0] s, input logic [7:0] d);
        begin
            host_en <= 1'b1;
            host_wr <= w;
            host_sel <= s;
            host_data <= d;
            chip_strobe_n <= 1'b0;
            repeat (3) @(posedge pclk);
            if (!w) chk({31'h0, d_oe}, 32'h1);
            if (!w) chk({24'h0, d_out}, {24'h0, d});
            chip_strobe_n <= 1'b1;
            @(posedge pclk);
            host_en <= 1'b0;
            @(posedge pclk);
            chk({31'h0, d_oe}, 32'h0);
        end
    endtask
    // 20 chars a line, 4-wide hsync, 2 scans a row, 2 rows, 2-line vsync, 8 lines a frame
    task run(input logic [4:0] m);
        begin
            apb(1'b1, `REG_HTOTAL, 32'h13);
            apb(1'b1, `REG_HSYNC, 32'h3);
            apb(1'b1, `REG_ROWFMT, 32'h0107);
            apb(1'b1, `REG_VFMT, 32'h0007_0101);
            apb(1'b1, `REG_MODE, {27'h0, m});
            apb(1'b1, `REG_COMMAND, {24'h0, `CMD_START});
            repeat (100) @(posedge pclk);
            {n_oe, n_dma, n_hs, n_vs, n_rb, n_do} = '0;
            repeat (480) begin
                @(posedge pclk);
                n_oe += (a_oe[0] === 1'b1);
                n_dma += (dma === 1'b1);
                n_hs += (hs === 1'b0);
                n_vs += (vs === 1'b0);
                n_rb += (rb_n === 1'b0);
                n_do += (d_oe === 1'b1);
            end
            apb(1'b1, `REG_COMMAND, {24'h0, `CMD_RESET});
        end
    endtask
    // ====
    // scenarios
    task t_reset_vals;
        begin
            chk({31'h0, hs}, 32'h1);
            apb(1'b0, `REG_HTOTAL, 0); chk(rd, {24'h0, `RST_HTOTAL});
            apb(1'b0, `REG_HSYNC, 0); chk(rd, {25'h0, `RST_HSYNC_W});
            apb(1'b0, `REG_ROWFMT, 0); chk(rd, {19'h0, `RST_SCANS, `RST_CHARS});
            apb(1'b0, `REG_VFMT, 0); chk(rd, {5'h0, `RST_SCAN_TOTAL, `RST_VSYNC_W, `RST_ROWS});
            apb(1'b0, 12'h100, 0); chk(rd, 32'h0);
            apb(1'b1, `REG_TABLE_START, 32'h1234);
            apb(1'b0, `REG_TABLE_START, 0); chk(rd, 32'h1234);
            chk({18'h0, a_out}, 32'h1234);
            $display("t_reset_vals done");
        end
    endtask
    task t_host_port;
        begin
            strobe(1'b1, 6'h0c, 8'ha5);
            apb(1'b0, `REG_HOSTREG, 0); chk({24'h0, rd[7:0]}, 32'ha5);
            strobe(1'b1, 6'h21, 8'h3c);
            apb(1'b0, `REG_HOSTREG, 0); chk({24'h0, rd[7:0]}, 32'h3c);
            strobe(1'b0, 6'h0c, 8'ha5);
            $display("t_host_port done");
        end
    endtask
    task t_format;
        begin
            run({3'h0, `BUF_NONE});
            chk(n_hs, 96);
            chk(n_vs, 120);
            chk(n_rb, 120);
            chk(n_oe, 96);
            chk({31'h0, irq}, 32'h1);
            apb(1'b0, `REG_STATUS, 0); chk(rd & 32'h100, 32'h100);
            chk({31'h0, irq}, 32'h0);
            $display("t_format done");
        end
    endtask
    task t_buffers;
        begin
            run({3'h0, `BUF_SINGLE}); chk({31'h0, n_oe != 0}, 32'h1);
            run({3'h1, `BUF_DOUBLE}); chk({31'h0, n_dma != 0}, 32'h1);
            run({3'h5, `BUF_SINGLE}); chk({31'h0, n_dma != 0}, 32'h1);
            run({3'h3, `BUF_NONE}); chk({31'h0, n_dma != 0}, 32'h1);
            chk({31'h0, n_do != 0}, 32'h1);
            $display("t_buffers done");
        end
    endtask
    task t_resets;
        begin
            apb(1'b1, `REG_MODE, {30'h0, `BUF_DOUBLE});
            apb(1'b1, `REG_COMMAND, {24'h0, `CMD_START});
            repeat (60) @(posedge pclk);
            apb(1'b1, `REG_COMMAND, {24'h0, `CMD_RESET});
            chk({31'h0, hs}, 32'h1);
            apb(1'b0, `REG_STATUS, 0); chk(rd & 32'h200, 32'h0);
            apb(1'b0, `REG_MODE, 0); chk(rd, 32'h0);
            apb(1'b1, `REG_MODE, {30'h0, `BUF_DOUBLE});
            apb(1'b1, `REG_COMMAND, {24'h0, `CMD_START});
            repeat (60) @(posedge pclk);
            presetn <= 1'b0;
            repeat (2) @(posedge pclk);
            presetn <= 1'b1;
            @(posedge pclk);
            apb(1'b0, `REG_STATUS, 0); chk(rd & 32'h200, 32'h0);
            apb(1'b0, `REG_MODE, 0); chk(rd, 32'h0);
            apb(1'b0, `REG_HTOTAL, 0); chk(rd, {24'h0, `RST_HTOTAL});
            $display("t_resets done");
        end
    endtask
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset_vals;
        t_host_port;
        t_format;
        t_buffers;
        t_resets;
        summarize;
    end
endmodule
`default_nettype wire
